// >>> verilog/timer_counter.sv
/*
 * Shared package for the buffered compare PWM timer, and the prescaled
 * 16-bit modulo counter that gives the timing reference for every channel.
 * Assumes one 20 MHz system clock, a synchronous active-low reset and a
 * clock enable that freezes all state while low.
 */
`default_nettype none

package timer_pwm_pkg;
   // ------------------------------------------------------------------
   // Widths and timing
   // ------------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int PSC_W = 6;
   localparam int CHAN_N = 4;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [2:0] PS_EXTERNAL = 3'h7;
   localparam logic [CNT_W-1:0] MODULO_RST = 16'hFFFF;
   localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;

   // ------------------------------------------------------------------
   // Register offsets (word index on the plain register port)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_TIMER_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_MODULO = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_CHAN_CTL0 = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_CHAN_CMP0 = 4'h7;

   // Timer status and control field positions
   localparam int TSC_OVF_BIT = 7;
   localparam int TSC_STOP_BIT = 5;
   localparam int TSC_RESET_BIT = 4;
   localparam int TSC_PS_LSB = 0;
   // Channel status and control field positions
   localparam int CTL_MODEB_BIT = 5;
   localparam int CTL_MODEA_BIT = 4;
   localparam int CTL_ELSB_BIT = 3;
   localparam int CTL_ELSA_BIT = 2;
   localparam int CTL_TOV_BIT = 1;
   localparam int CTL_MAX_BIT = 0;
   localparam logic [5:0] CTL_RST = 6'h00;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_OFF = 3'h1,
      MODE_UNBUF = 3'h2,
      MODE_BUF = 3'h4
   } chanMode_e;

   typedef enum logic [3:0] {
      ACT_NONE = 4'h1,
      ACT_TOGGLE = 4'h2,
      ACT_CLEAR = 4'h4,
      ACT_SET = 4'h8
   } cmpAction_e;

   typedef struct packed {
      logic modeB;
      logic modeA;
      logic elsB;
      logic elsA;
      logic tov;
      logic maxDuty;
   } chanCtl_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } regReq_s;

   typedef struct packed {
      logic [PSC_W-1:0] psc;
      logic [CNT_W-1:0] count;
   } cntState_s;

   // Next count of the modulo up-counter
   function automatic logic [CNT_W-1:0] nextCount(input logic [CNT_W-1:0] cnt,
                                                 input logic [CNT_W-1:0] modv);
      nextCount = (cnt == modv) ? COUNT_RST : CNT_W'(cnt + 16'h0001);
   endfunction
endpackage

`timescale 1ns/1ps

module timer_counter (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // Control
   input wire logic counterStop,
   input wire logic counterReset,
   input wire logic [2:0] prescale,
   input wire logic [timer_pwm_pkg::CNT_W-1:0] moduloValue,
   // Status
   output logic [timer_pwm_pkg::CNT_W-1:0] count,
   output logic tick,
   output logic overflow
);
   import timer_pwm_pkg::*;

   cntState_s stateQ, stateD;
   logic [PSC_W-1:0] mask;

   // --------------------------------------------------------------
   // Prescaler tap: a divide by 2^n ticks when the low n bits are ones
   // --------------------------------------------------------------
   always_comb begin
      mask = PSC_W'((7'h01 << prescale) - 7'h01);
      if (prescale == PS_EXTERNAL) begin
         tick = 1'b0; // No external clock pin in this block
      end else begin
         tick = clkEn && !counterStop && ((stateQ.psc & mask) == mask);
      end
      overflow = tick && (stateQ.count == moduloValue); // [RQ18]
      count = stateQ.count;
   end

   // Next state
   always_comb begin
      stateD = stateQ;
      if (counterReset) begin
         stateD.psc = '0; // [RQ19]
         stateD.count = COUNT_RST; // [RQ19]
      end else if (!counterStop) begin
         stateD.psc = PSC_W'(stateQ.psc + 6'h01);
         if (tick) begin
            stateD.count = nextCount(stateQ.count, moduloValue); // [RQ18]
         end
      end
   end

   // State register; the stop input simply withholds the update [RQ20]
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stateQ <= '0;
      end else if (clkEn) begin
         stateQ <= stateD;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   stop_holds_a: assert property (clkEn && counterStop && !counterReset |=> $stable(count)) // [RQ20]
      else $error("counter moved while stopped");
   reset_clears_a: assert property (clkEn && counterReset |=> count == COUNT_RST) // [RQ19]
      else $error("counter reset did not clear count");
   wrap_zero_a: assert property (overflow && !counterReset |=> count == COUNT_RST) // [RQ18]
      else $error("count did not restart after overflow");
endmodule

`default_nettype wire

// >>> verilog/timer_buffered_compare_pwm.sv
/*
 * Output compare and PWM logic of a four-channel 16-bit timer with
 * pairwise buffered compare registers, plus its plain register port.
 * Assumes a register master on the same clock: one-cycle strobes, read
 * data returned in the cycle after the read strobe.
 */
// Strobed register access and the placing of the registers were decided locally.
// Functional notes
// RQ1: Pair-zero link: channel zero pin, value zero first
// RQ2: Other set written takes over at overflow
// RQ3: Linked: channel-one control ignored, pin released
// RQ4: Pair two links likewise on channel two pin
// RQ5: Software writes only the inactive set
// RQ6: Toggle on overflow sets the PWM period
// RQ7: Compare match drives configured action level
// RQ8: Modulo 255, divide one: 256-cycle period
// RQ9: Compare 128 of 256 gives half duty
// RQ10: Eight-bit period and width in 256 steps
// RQ11: Software times unbuffered width changes safely
// RQ12: Software avoids toggle-on-compare in PWM
// RQ13: Software initialises PWM in fixed order
// RQ14: Decode mode and edge/level bit pairs
// RQ15: Link mode bit overrides the other mode bit
// RQ16: No overflow toggle gives steady zero duty
// RQ17: Max-duty with toggle gives full duty
// RQ18: Overflow at modulo sets flag, count restarts
// RQ19: Counter reset clears count and prescaler, self-clears
// RQ20: Stop holds counter; reset leaves it stopped
// RQ21: Active-set selector changes only at overflow
`default_nettype none
`timescale 1ns/1ps

module timer_buffered_compare_pwm (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // Register port
   input wire timer_pwm_pkg::regReq_s regReq,
   output logic [timer_pwm_pkg::DATA_W-1:0] regRdata,
   // Channel pins
   output logic [timer_pwm_pkg::CHAN_N-1:0] chanPinOut,
   output logic [timer_pwm_pkg::CHAN_N-1:0] chanPinOe,
   // Status
   output logic overflowFlag
);
   import timer_pwm_pkg::*;

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   typedef struct packed {
      logic stop;
      logic [2:0] prescale;
      logic ovf;
      logic [CNT_W-1:0] modulo;
      chanCtl_s [CHAN_N-1:0] ctl;
      logic [CHAN_N-1:0][CNT_W-1:0] cmp;
      logic [CHAN_N-1:0] pin;
      logic [1:0] sel;
      logic [1:0] lastWr;
      logic [DATA_W-1:0] rdata;
   } pwmState_s;

   pwmState_s stateQ, stateD;

   // --------------------------------------------------------------
   // Decode helpers
   // --------------------------------------------------------------
   // Mode pair: link bit wins over the other mode bit
   function automatic chanMode_e decodeMode(input chanCtl_s c, input logic linkable);
      if (c.modeB && linkable) begin
         decodeMode = MODE_BUF; // [RQ14] [RQ15]
      end else if (c.modeA || c.modeB) begin
         decodeMode = MODE_UNBUF; // [RQ14]
      end else begin
         decodeMode = MODE_OFF;
      end
   endfunction

   // Edge/level pair: 0:1 toggle, 1:0 clear, 1:1 set
   function automatic cmpAction_e decodeAction(input chanCtl_s c);
      case ({c.elsB, c.elsA})
         2'b01: decodeAction = ACT_TOGGLE;
         2'b10: decodeAction = ACT_CLEAR; // [RQ14]
         2'b11: decodeAction = ACT_SET; // [RQ14]
         default: decodeAction = ACT_NONE;
      endcase
   endfunction

   // Register offset of a channel control or compare word
   function automatic logic isChanReg(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base, input int ch);
      isChanReg = (a == ADDR_W'(base + ADDR_W'(ch)));
   endfunction

   // --------------------------------------------------------------
   // Counter
   // --------------------------------------------------------------
   logic [CNT_W-1:0] count;
   logic tick;
   logic overflow;
   logic counterReset;
   logic [CNT_W-1:0] countNext;

   // The reset control is a write strobe only, so it never reads back [RQ19]
   assign counterReset = regReq.wr && (regReq.addr == OFS_TIMER_STATUS)
                         && regReq.wdata[TSC_RESET_BIT];

   timer_counter counter_i (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .counterStop(stateQ.stop),
      .counterReset(counterReset),
      .prescale(stateQ.prescale),
      .moduloValue(stateQ.modulo),
      .count(count),
      .tick(tick),
      .overflow(overflow)
   );

   // Compares look at the count the tick is about to load, so a value of
   // N ends the pulse after exactly N timer clocks from overflow [RQ7] [RQ9]
   assign countNext = nextCount(count, stateQ.modulo);

   // --------------------------------------------------------------
   // Per-channel decode
   // --------------------------------------------------------------
   logic [1:0] linked;
   chanMode_e [CHAN_N-1:0] mode;
   cmpAction_e [CHAN_N-1:0] action;
   logic [CHAN_N-1:0] active;
   logic [CHAN_N-1:0][CNT_W-1:0] effCmp;
   logic [CHAN_N-1:0] match;

   always_comb begin
      linked[0] = stateQ.ctl[0].modeB; // [RQ1]
      linked[1] = stateQ.ctl[2].modeB; // [RQ4]
      for (int c = 0; c < CHAN_N; c++) begin
         mode[c] = decodeMode(stateQ.ctl[c], (c % 2) == 0);
         action[c] = decodeAction(stateQ.ctl[c]);
         // Odd channel of a linked pair is idle and gives up its pin [RQ3] [RQ4]
         active[c] = (mode[c] != MODE_OFF) && (action[c] != ACT_NONE)
                     && !((c % 2 == 1) && linked[c/2]);
         // Linked even channel reads the set chosen by the selector [RQ1] [RQ2]
         if ((c % 2 == 0) && linked[c/2] && stateQ.sel[c/2]) begin
            effCmp[c] = stateQ.cmp[c+1];
         end else begin
            effCmp[c] = stateQ.cmp[c];
         end
         match[c] = tick && (countNext == effCmp[c]);
      end
   end

   // --------------------------------------------------------------
   // Next state: register writes, selectors, pins, flag
   // --------------------------------------------------------------
   always_comb begin
      stateD = stateQ;
      // Timer status and control
      if (regReq.wr && regReq.addr == OFS_TIMER_STATUS) begin
         stateD.stop = regReq.wdata[TSC_STOP_BIT]; // [RQ20]
         stateD.prescale = regReq.wdata[TSC_PS_LSB +: 3];
         if (!regReq.wdata[TSC_OVF_BIT]) begin
            stateD.ovf = 1'b0;
         end
      end
      if (regReq.wr && regReq.addr == OFS_MODULO) begin
         stateD.modulo = regReq.wdata[CNT_W-1:0];
      end
      // Overflow after the clear so a same-cycle event is kept [RQ18]
      if (overflow) begin
         stateD.ovf = 1'b1;
      end

      // Active-set selector moves only at overflow while linked, and is held at zero while unlinked [RQ2] [RQ21]
      for (int p = 0; p < 2; p++) begin
         if (!linked[p]) begin
            stateD.sel[p] = 1'b0; // Even set first on linking [RQ1] [RQ4]
            stateD.lastWr[p] = 1'b0;
         end else if (overflow) begin
            stateD.sel[p] = stateQ.lastWr[p]; // [RQ21]
         end
      end

      for (int c = 0; c < CHAN_N; c++) begin
         if (regReq.wr && isChanReg(regReq.addr, OFS_CHAN_CTL0, c)) begin
            stateD.ctl[c] = chanCtl_s'(regReq.wdata[5:0]);
         end
         if (regReq.wr && isChanReg(regReq.addr, OFS_CHAN_CMP0, c)) begin
            stateD.cmp[c] = regReq.wdata[CNT_W-1:0];
            // Remember which set of the pair software wrote last [RQ2]
            if (linked[c/2]) begin
               stateD.lastWr[c/2] = (c % 2 == 1);
            end
         end

         // Pin action: an overflow toggle wins over the compare level in the same cycle
         if (active[c]) begin
            if (overflow && stateQ.ctl[c].tov) begin
               if (stateQ.ctl[c].maxDuty) begin
                  stateD.pin[c] = 1'b1; // [RQ17]
               end else begin
                  stateD.pin[c] = !stateQ.pin[c]; // [RQ6] [RQ8] [RQ10]
               end
            end else if (match[c] && !(stateQ.ctl[c].tov && stateQ.ctl[c].maxDuty)) begin
               // Without overflow toggles this re-forces the held level [RQ16]
               case (action[c])
                  ACT_TOGGLE: stateD.pin[c] = !stateQ.pin[c];
                  ACT_CLEAR: stateD.pin[c] = 1'b0; // [RQ7]
                  ACT_SET: stateD.pin[c] = 1'b1; // [RQ7]
                  default: stateD.pin[c] = stateQ.pin[c];
               endcase
            end
         end
      end

      // Read data for the cycle after the strobe
      stateD.rdata = '0;
      if (regReq.rd) begin
         if (regReq.addr == OFS_TIMER_STATUS) begin
            stateD.rdata[TSC_OVF_BIT] = stateQ.ovf;
            stateD.rdata[TSC_STOP_BIT] = stateQ.stop;
            stateD.rdata[TSC_PS_LSB +: 3] = stateQ.prescale;
         end else if (regReq.addr == OFS_COUNT) begin
            stateD.rdata = count;
         end else if (regReq.addr == OFS_MODULO) begin
            stateD.rdata = stateQ.modulo;
         end else if (regReq.addr >= OFS_CHAN_CTL0 && regReq.addr < OFS_CHAN_CMP0) begin
            stateD.rdata[5:0] = stateQ.ctl[2'(regReq.addr - OFS_CHAN_CTL0)];
         end else if (regReq.addr >= OFS_CHAN_CMP0
                      && regReq.addr < ADDR_W'(OFS_CHAN_CMP0 + 4'h4)) begin
            stateD.rdata = stateQ.cmp[2'(regReq.addr - OFS_CHAN_CMP0)];
         end
      end
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   // Reset leaves the counter stopped and the modulo at full range [RQ20]
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stateQ.stop <= 1'b1;
         stateQ.prescale <= 3'h0;
         stateQ.ovf <= 1'b0;
         stateQ.modulo <= MODULO_RST;
         stateQ.ctl <= {CHAN_N{CTL_RST}};
         stateQ.cmp <= '0;
         stateQ.pin <= '0;
         stateQ.sel <= 2'h0;
         stateQ.lastWr <= 2'h0;
         stateQ.rdata <= '0;
      end else if (clkEn) begin
         stateQ <= stateD;
      end
   end

   // Outputs; released pins keep their driver off so the port can take them
   always_comb begin
      regRdata = stateQ.rdata;
      overflowFlag = stateQ.ovf;
      chanPinOut = stateQ.pin;
      chanPinOe = active;
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   pair0_pin1_free_a: assert property (linked[0] |-> !chanPinOe[1]) // [RQ3]
      else $error("channel one pin driven while pair zero linked");
   pair2_pin3_free_a: assert property (linked[1] |-> !chanPinOe[3]) // [RQ4]
      else $error("channel three pin driven while pair two linked");
   link_starts_even_a: assert property (clkEn && !linked[0] ##1 linked[0] |-> !stateQ.sel[0]) // [RQ1]
      else $error("linked pair zero did not start on channel zero values");
   sel_switch_a: assert property (linked[0] && overflow && stateQ.lastWr[0] ##1 linked[0]
                                  |-> stateQ.sel[0]) // [RQ2]
      else $error("written channel one set did not take over at overflow");
   sel_hold_a: assert property (clkEn && linked[0] && !overflow ##1 linked[0]
                                |-> $stable(stateQ.sel[0])) // [RQ21]
      else $error("active set changed without overflow");
   ovf_toggle_a: assert property (overflow && active[0] && stateQ.ctl[0].tov
                                  && !stateQ.ctl[0].maxDuty |=> chanPinOut[0] != $past(chanPinOut[0])) // [RQ6]
      else $error("pin did not toggle at overflow");
   full_duty_a: assert property (active[0] && stateQ.ctl[0].tov && stateQ.ctl[0].maxDuty
                                 && overflow |=> chanPinOut[0] [*2]) // [RQ17]
      else $error("full duty output not high");
   clear_match_a: assert property (match[0] && !overflow && active[0] && !stateQ.ctl[0].tov
                                   && action[0] == ACT_CLEAR |=> !chanPinOut[0]) // [RQ7]
      else $error("compare clear did not drive pin low");
   zero_duty_a: assert property (active[0] && !stateQ.ctl[0].tov && !chanPinOut[0]
                                 && action[0] == ACT_CLEAR && !regReq.wr |=> !chanPinOut[0]) // [RQ16]
      else $error("zero duty output left low level");
   ovf_flag_a: assert property (overflow |=> overflowFlag) // [RQ18]
      else $error("overflow flag not set");
   reset_bit_zero_a: assert property (regReq.rd && regReq.addr == OFS_TIMER_STATUS
                                      |=> !regRdata[TSC_RESET_BIT]) // [RQ19]
      else $error("counter reset control read as one");
   buf_priority_a: assert property (stateQ.ctl[2].modeB |-> mode[2] == MODE_BUF) // [RQ15]
      else $error("link bit did not select buffered mode");
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
/*
 * Self-checking bench for the buffered compare PWM timer: register port,
 * counter stop and reset, overflow flag, PWM period and width, zero and
 * full duty, and the linked channel pairs.
 * Assumes the design package and modules are compiled first; the bench
 * drives the register port itself, with no separate partner model.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin numChecks++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end

module tb_top;
   import timer_pwm_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_sys;
   logic rst_n;
   logic clkEn;
   regReq_s regReq;
   logic [DATA_W-1:0] regRdata;
   logic [CHAN_N-1:0] chanPinOut;
   logic [CHAN_N-1:0] chanPinOe;
   logic overflowFlag;
   int miscompares = 0;
   int numChecks = 0;
   int seed = 32'hc914;
   int tAt, tOther, mod, cmp, ch;
   logic [DATA_W-1:0] rdVal;
   logic setMode;

   timer_buffered_compare_pwm DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .regReq(regReq),
      .regRdata(regRdata), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe),
      .overflowFlag(overflowFlag));

   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Register port and measurement tasks
   // ----------------------------------------------------------------
   // One-cycle write strobe
   task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      regReq.wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, so sample it there
   task automatic regRead(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      regReq.rd <= 1'b0;
      @(negedge clk_sys);
      d = regRdata;
   endtask

   // Cycles spent at lvl, then at the other level, over one full period
   task automatic measure(input int pin, input logic lvl, output int nAt, output int nOff);
      int n;
      n = 0;
      while (chanPinOut[pin] === lvl && n < 2000) begin @(negedge clk_sys); n++; end
      n = 0;
      while (chanPinOut[pin] !== lvl && n < 2000) begin @(negedge clk_sys); n++; end
      nAt = 0;
      while (chanPinOut[pin] === lvl && nAt < 2000) begin @(negedge clk_sys); nAt++; end
      nOff = 0;
      while (chanPinOut[pin] !== lvl && nOff < 2000) begin @(negedge clk_sys); nOff++; end
   endtask

   // Number of cycles within n where the pin left lvl
   task automatic steady(input int pin, input logic lvl, input int n, output int bad);
      bad = 0;
      repeat (n) begin
         @(negedge clk_sys);
         if (chanPinOut[pin] !== lvl) bad++;
      end
   endtask

   // Stop, clear, period, width, mode, then restart; a restart clears the flag.
   // Widths only change while stopped, so no period can be corrupted.
   task automatic pwm(input int c, input logic [5:0] ctl, input int m, input int w);
      regWrite(OFS_TIMER_STATUS, 16'h0030);
      regWrite(OFS_MODULO, 16'(m));
      regWrite(OFS_CHAN_CMP0 + 4'(c), 16'(w));
      regWrite(OFS_CHAN_CTL0 + 4'(c), {10'h000, ctl});
      regWrite(OFS_TIMER_STATUS, 16'h0000);
   endtask

   // Expected cycles at the pulse level (first) or at the rest level
   function automatic int pulseLen(input int m, input int w, input bit first);
      return first ? w : m + 1 - w;
   endfunction

   task automatic conclude;
      $display("checks %0d mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (40000) @(posedge clk_sys);
      miscompares++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      regReq = '0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset state: stopped counter, full modulo, pins released
      regRead(OFS_TIMER_STATUS, rdVal);
      `CHK("status after reset", 16'h0020, rdVal)
      regRead(OFS_MODULO, rdVal);
      `CHK("modulo after reset", 16'hFFFF, rdVal)
      regRead(4'hB, rdVal);
      `CHK("unmapped read", 16'h0000, rdVal)
      `CHK("oe after reset", 4'h0, chanPinOe)
      repeat (20) @(posedge clk_sys);
      regRead(OFS_COUNT, rdVal);
      `CHK("count held while stopped", 16'h0000, rdVal)
      $display("test reset done");

      // Eight-bit PWM, divide by one, half duty
      pwm(0, 6'h1A, 255, 128);
      measure(0, 1'b1, tAt, tOther);
      `CHK("half duty high", 128, tAt)
      `CHK("half duty period", 256, tAt + tOther)
      `CHK("overflow flag", 1'b1, overflowFlag)
      regRead(OFS_TIMER_STATUS, rdVal);
      `CHK("status flag bit", 1'b1, rdVal[TSC_OVF_BIT])
      $display("test pwm half done");

      // Divide by four: every timer clock spans four system clocks
      pwm(0, 6'h1A, 15, 8);
      regWrite(OFS_TIMER_STATUS, 16'h0002);
      measure(0, 1'b1, tAt, tOther);
      `CHK("prescaled high", 32, tAt)
      `CHK("prescaled period", 64, tAt + tOther)
      $display("test prescale done");

      // Random period, width, channel and polarity
      repeat (6) begin
         mod = 16 + ($unsigned($random(seed)) % 240);
         cmp = 1 + ($unsigned($random(seed)) % mod);
         ch = $unsigned($random(seed)) % 4;
         setMode = 1'($random(seed));
         // Never toggle-on-compare: only clear or set actions are used
         pwm(ch, setMode ? 6'h1E : 6'h1A, mod, cmp);
         measure(ch, ~setMode, tAt, tOther);
         `CHK("pulse width", pulseLen(mod, cmp, 1'b1), tAt)
         `CHK("rest time", pulseLen(mod, cmp, 1'b0), tOther)
         `CHK("unbuffered oe", 1'b1, chanPinOe[ch])
      end
      $display("test pwm random done");

      // No overflow toggle: output settles low and stays there
      pwm(0, 6'h18, 255, 128);
      repeat (300) @(posedge clk_sys);
      steady(0, 1'b0, 300, tAt);
      `CHK("zero duty", 0, tAt)
      // Maximum duty with overflow toggle: output stays high
      pwm(0, 6'h1B, 255, 128);
      repeat (300) @(posedge clk_sys);
      steady(0, 1'b1, 300, tAt);
      `CHK("full duty", 0, tAt)
      $display("test duty limits done");

      // Linked pairs; mode A is also set to show that the link bit wins
      for (int p = 0; p < 4; p += 2) begin
         regWrite(OFS_CHAN_CTL0 + 4'(p + 1), 16'h001A);
         pwm(p, 6'h3A, 255, 64);
         measure(p, 1'b1, tAt, tOther);
         `CHK("even set first", 64, tAt)
         `CHK("odd pin released", 1'b0, chanPinOe[p + 1])
         `CHK("even pin driven", 1'b1, chanPinOe[p])
         // Writes go to the set that is not active at the time
         regWrite(OFS_CHAN_CMP0 + 4'(p + 1), 16'h00C0);
         measure(p, 1'b1, tAt, tOther);
         `CHK("odd set after overflow", 192, tAt)
         regWrite(OFS_CHAN_CMP0 + 4'(p), 16'h0020);
         measure(p, 1'b1, tAt, tOther);
         `CHK("last written set", 32, tAt)
         `CHK("linked period", 256, tAt + tOther)
      end
      $display("test linked pairs done");

      // Stop together with counter reset parks the count at zero
      regWrite(OFS_TIMER_STATUS, 16'h00B0);
      regRead(OFS_COUNT, rdVal);
      `CHK("count cleared", 16'h0000, rdVal)
      regRead(OFS_TIMER_STATUS, rdVal);
      `CHK("reset bit reads zero", 1'b0, rdVal[TSC_RESET_BIT])
      `CHK("flag kept by writing one", 1'b1, overflowFlag)
      repeat (30) @(posedge clk_sys);
      regRead(OFS_COUNT, rdVal);
      `CHK("count still held", 16'h0000, rdVal)
      regWrite(OFS_TIMER_STATUS, 16'h0020);
      @(negedge clk_sys);
      `CHK("flag cleared", 1'b0, overflowFlag)
      regRead(OFS_TIMER_STATUS, rdVal);
      `CHK("status after clear", 16'h0020, rdVal)
      $display("test stop and reset done");
      conclude();
   end
endmodule

`default_nettype wire
